// file: hdl/phy_event_defs.svh
// Offsets, field positions, reset values and limits for the event block.
// Assumes it is included by bare name from the design files.
`ifndef PHY_EVENT_DEFS_SVH
`define PHY_EVENT_DEFS_SVH
// Register indices; the byte address is four times the index.
`define IDX_CTRL 6'h11
`define IDX_ESE1 6'h12
`define IDX_ESE2 6'h13
`define IDX_FCC 6'h14
`define IDX_REC 6'h15
// Control field positions and reset value (polarity set).
`define CTRL_OE 0
`define CTRL_GIE 1
`define CTRL_TINT 2
`define CTRL_POL 3
`define CTRL_RST 4'h8
// Counter limits and half-full thresholds.
`define FC_MAX 8'hff
`define FC_HALF 8'h7f
`define RE_MAX 16'hffff
`define RE_HALF 16'h7fff
`endif

// file: hdl/phy_event_pkg.sv
// Types shared by the event block.
// Assumes nothing of its surroundings.
package phy_event_pkg;
   // Whole state of the block, registered in one process.
   typedef struct packed {
      logic        ack;       // Bus answer cycle.
      logic [15:0] rdata;     // Captured read value.
      logic [3:0]  ctrl;      // Polarity, test, global, output.
      logic [5:0]  stat1;     // Status one, bits 13:8.
      logic [5:0]  en1;       // Enables one, bits 5:0.
      logic [6:0]  stat2;     // Status two, bits 14:8.
      logic [6:0]  en2;       // Enables two, bits 6:0.
      logic [7:0]  false_carrier_tally; // False-carrier count.
      logic [15:0] rx_error_tally;      // Receive error count.
      logic        pd_meta;   // First synchroniser stage.
      logic        pd_sync;   // Second synchroniser stage.
      logic        pwr_down;  // Power-down request.
      logic        irq;       // Interrupt active.
      logic        pin;       // Pin output level.
   } state_s;
endpackage

// file: hdl/phy_event_irq.sv
// Event status, interrupt enables and management counters of the PHY.
// Assumes event inputs are one-cycle pulses on mclk and the shared
// interrupt pin input is asynchronous.
//
// Chosen here: register access over Avalon-MM.
`include "phy_event_defs.svh"

module phy_event_irq (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        ev_link_change,
   input  wire logic        ev_speed_change,
   input  wire logic        ev_duplex_change,
   input  wire logic        ev_negotiation_complete,
   input  wire logic        ev_negotiation_error,
   input  wire logic        ev_page_received,
   input  wire logic        ev_loopback_fifo_fault,
   input  wire logic        ev_crossover_change,
   input  wire logic        ev_sleep,
   input  wire logic        ev_polarity_change,
   input  wire logic        ev_jabber,
   input  wire logic        false_carrier_event,
   input  wire logic        rx_symbol_error,
   input  wire logic        rx_dv,
   input  wire logic        carrier_valid,
   input  wire logic        mii_loopback,
   input  wire logic        int_pin_in,
   output logic             int_pin_out,
   output logic             int_pin_oe,
   output logic             power_down
);

   // Reset image of the whole state.
   localparam phy_event_pkg::state_s ST_RST = '{
      ack: 1'b0,
      rdata: 16'h0000,
      ctrl: `CTRL_RST,
      stat1: 6'h00,
      en1: 6'h00,
      stat2: 7'h00,
      en2: 7'h00,
      false_carrier_tally: 8'h00,
      rx_error_tally: 16'h0000,
      pd_meta: 1'b1,
      pd_sync: 1'b1,
      pwr_down: 1'b0,
      irq: 1'b0,
      pin: 1'b1
   };

   phy_event_pkg::state_s st;      // Present state.
   phy_event_pkg::state_s next_st; // Next state.

   // True when the byte address selects the given register index.
   function automatic logic sel(input logic [7:0] a,
                                input logic [5:0] idx);
      sel = (a == {idx, 2'b00});
   endfunction

   logic        req;     // A request is on the bus.
   logic        acc_rd;  // Read takes effect this edge.
   logic        acc_wr;  // Write takes effect this edge.
   logic        rd1;     // Read of status one.
   logic        rd2;     // Read of status two.
   logic        rdf;     // Read of false-carrier count.
   logic        rdr;     // Read of receive error count.
   logic        wr_lo;   // Write touching the low byte.
   logic [15:0] val;     // Value of the addressed register.
   logic        fc_inc;  // False-carrier increment request.
   logic        re_inc;  // Receive error increment request.
   logic [7:0]  fc_base; // False-carrier count after read.
   logic [15:0] re_base; // Receive error count after read.
   logic        fc_half; // False-carrier half-full event.
   logic        re_half; // Receive error half-full event.
   logic [5:0]  ev1;     // Events of status one.
   logic [6:0]  ev2;     // Events of status two.
   logic        pend;    // Some enabled bit is pending.
   logic        irq_nx;  // Interrupt level for next cycle.

   // Each access waits one cycle so read data stand from a flop.
   assign req = read | write;
   assign waitrequest = req & ~st.ack;
   assign acc_rd = read & st.ack;
   assign acc_wr = write & st.ack;
   assign wr_lo = acc_wr & byteenable[0];

   // Decode of clearing reads.
   assign rd1 = acc_rd & sel(address, `IDX_ESE1);
   assign rd2 = acc_rd & sel(address, `IDX_ESE2);
   assign rdf = acc_rd & sel(address, `IDX_FCC);
   assign rdr = acc_rd & sel(address, `IDX_REC);

   // Register read mux; reserved and unmapped bits read zero.
   always_comb begin
      if (sel(address, `IDX_CTRL)) begin
         val = {12'h000, st.ctrl};
      end else if (sel(address, `IDX_ESE1)) begin
         val = {2'b00, st.stat1, 2'b00, st.en1};
      end else if (sel(address, `IDX_ESE2)) begin
         val = {1'b0, st.stat2, 1'b0, st.en2};
      end else if (sel(address, `IDX_FCC)) begin
         val = {8'h00, st.false_carrier_tally};
      end else if (sel(address, `IDX_REC)) begin
         val = st.rx_error_tally;
      end else begin
         val = 16'h0000;
      end
   end

   // Increment requests of the two counters.
   assign fc_inc = false_carrier_event;
   assign re_inc = carrier_valid & rx_dv & rx_symbol_error
                 & ~mii_loopback;

   // A read removes only what it returned, so no count is lost.
   assign fc_base = rdf ? st.false_carrier_tally - st.rdata[7:0]
                        : st.false_carrier_tally;
   assign re_base = rdr ? st.rx_error_tally - st.rdata
                        : st.rx_error_tally;

   // Half-full fires only on the step from the threshold upward.
   assign fc_half = fc_inc & (fc_base == `FC_HALF);
   assign re_half = re_inc & (re_base == `RE_HALF);

   // Event vectors in status bit order, high bit first.
   assign ev1 = {ev_link_change, ev_speed_change, ev_duplex_change,
                 ev_negotiation_complete, fc_half, re_half};
   assign ev2 = {ev_negotiation_error, ev_page_received,
                 ev_loopback_fifo_fault, ev_crossover_change,
                 ev_sleep, ev_polarity_change, ev_jabber};

   // Level request while any pending bit has its enable set.
   assign pend = (|(st.stat1 & st.en1)) | (|(st.stat2 & st.en2));

   // Gate onto the pin; test bit forces a request.
   assign irq_nx = st.ctrl[`CTRL_OE]
                 & ((st.ctrl[`CTRL_GIE] & pend)
                    | st.ctrl[`CTRL_TINT]);

   // Next-state logic of the whole block.
   always_comb begin
      next_st = st;
      next_st.ack = req & ~st.ack;
      // Capture read data in the waiting cycle.
      if (req & ~st.ack) begin
         next_st.rdata = val;
      end
      // Status bits: clear what the read returned, set wins.
      next_st.stat1 = (st.stat1 & ~(rd1 ? st.rdata[13:8] : 6'h00))
                    | ev1;
      next_st.stat2 = (st.stat2 & ~(rd2 ? st.rdata[14:8] : 7'h00))
                    | ev2;
      // Counters saturate at their maximum.
      if (fc_inc && (fc_base != `FC_MAX)) begin
         next_st.false_carrier_tally = fc_base + 8'h01;
      end else begin
         next_st.false_carrier_tally = fc_base;
      end
      if (re_inc && (re_base != `RE_MAX)) begin
         next_st.rx_error_tally = re_base + 16'h0001;
      end else begin
         next_st.rx_error_tally = re_base;
      end
      // Writes reach only writable bits in the low byte.
      if (wr_lo && sel(address, `IDX_CTRL)) begin
         next_st.ctrl = writedata[3:0];
      end
      if (wr_lo && sel(address, `IDX_ESE1)) begin
         next_st.en1 = writedata[5:0];
      end
      if (wr_lo && sel(address, `IDX_ESE2)) begin
         next_st.en2 = writedata[6:0];
      end
      // Pin input synchroniser and power-down decode.
      next_st.pd_meta = int_pin_in;
      next_st.pd_sync = st.pd_meta;
      next_st.pwr_down = ~st.ctrl[`CTRL_OE] & ~st.pd_sync;
      // Interrupt level and pin polarity.
      next_st.irq = irq_nx;
      next_st.pin = st.ctrl[`CTRL_POL] ^ irq_nx;
   end

   // State register with synchronous reset.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state.
   assign readdata = {16'h0000, st.rdata};
   assign int_pin_out = st.pin;
   assign int_pin_oe = st.ctrl[`CTRL_OE];
   assign power_down = st.pwr_down;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // A clearing read of status one.
   sequence s_read_one;
      rd1;
   endsequence

   // A read of the false-carrier count with no new event.
   sequence s_read_fc_quiet;
      rdf && !fc_inc;
   endsequence

   // A clearing read of status two.
   sequence s_read_two;
      rd2;
   endsequence

   // A request that is still waiting for its answer.
   sequence s_bus_wait;
      (read || write) && waitrequest;
   endsequence

   // Duplex event is recorded whatever the enables.
   chk_status_latch: assert property (
      ev_duplex_change |=> st.stat1[3])
      else $error("duplex event not latched");

   // Read of status one with no events leaves returned bits clear.
   chk_read_clears: assert property (
      s_read_one ##0 (ev1 == 6'h00) |=> ((st.stat1 & $past(st.rdata[13:8]))
                                        == 6'h00))
      else $error("status one not cleared by read");

   // Event during the clearing read stays set.
   chk_set_wins: assert property (
      s_read_one ##0 ev_link_change |=> st.stat1[5])
      else $error("event lost under clearing read");

   // No interrupt without output enable.
   chk_irq_gate: assert property (
      !st.ctrl[`CTRL_OE] |=> !st.irq)
      else $error("interrupt without output enable");

   // Test bit with output enable drives interrupt.
   chk_test_irq: assert property (
      st.ctrl[`CTRL_OE] && st.ctrl[`CTRL_TINT] |=> st.irq)
      else $error("test interrupt not driven");

   // Pending enabled bit with both enables holds the level.
   chk_irq_level: assert property (
      st.ctrl[`CTRL_OE] && st.ctrl[`CTRL_GIE] && pend |=> st.irq)
      else $error("interrupt level dropped while pending");

   // Pin level follows polarity and interrupt.
   chk_pin_polarity: assert property (
      ##1 (int_pin_out == ($past(st.ctrl[`CTRL_POL]) ^ st.irq)))
      else $error("pin level wrong for polarity");

   // False-carrier count holds at its maximum.
   chk_fc_saturate: assert property (
      st.false_carrier_tally == `FC_MAX && !rdf |=>
         st.false_carrier_tally == `FC_MAX)
      else $error("false-carrier count wrapped");

   // Step past half raises the half-full flag.
   chk_fc_half: assert property (
      fc_inc && fc_base == `FC_HALF |=> st.stat1[1])
      else $error("false-carrier half-full not flagged");

   // Quiet read of the count returns it to zero.
   chk_fc_clear: assert property (
      s_read_fc_quiet ##0 (st.rdata[7:0] == st.false_carrier_tally)
         |=> st.false_carrier_tally == 8'h00)
      else $error("false-carrier count not cleared");

   // Loopback blocks receive error counting.
   chk_re_loopback: assert property (
      mii_loopback && !rdr |=> $stable(st.rx_error_tally))
      else $error("receive errors counted in loopback");

   // Receive error count holds at its maximum.
   chk_re_saturate: assert property (
      st.rx_error_tally == `RE_MAX && !rdr |=>
         st.rx_error_tally == `RE_MAX)
      else $error("receive error count wrapped");

   // Step past half raises the receive half-full flag.
   chk_re_half: assert property (
      re_inc && re_base == `RE_HALF |=> st.stat1[0])
      else $error("receive half-full not flagged");

   // Reserved bits of status one read zero.
   chk_reserved_zero: assert property (
      st.ack && read && sel(address, `IDX_ESE1) |->
         (readdata[15:14] == 2'b00) && (readdata[7:6] == 2'b00))
      else $error("reserved bits read nonzero");

   // Read of status two with no events leaves returned bits clear.
   chk_read_two_clears: assert property (
      s_read_two ##0 (ev2 == 7'h00)
         |=> ((st.stat2 & $past(st.rdata[14:8])) == 7'h00))
      else $error("status two not cleared by read");

   // The link status bit stays set until a read of status one.
   chk_status_hold: assert property (
      !rd1 && st.stat1[5] |=> st.stat1[5])
      else $error("link status bit lost without read");

   // The negotiation error event latches into status two whatever the enables.
   chk_stat2_latch: assert property (
      ev_negotiation_error |=> st.stat2[6])
      else $error("negotiation error not latched");

   // The jabber event latches into the lowest flag of status two.
   chk_jabber_latch: assert property (
      ev_jabber |=> st.stat2[0])
      else $error("jabber event not latched");

   // With nothing pending and no test bit the request drops.
   chk_irq_release: assert property (
      !pend && !st.ctrl[`CTRL_TINT] |=> !st.irq)
      else $error("interrupt held with nothing pending");

   // Without the global enable only the test bit may request.
   chk_gie_gate: assert property (
      !st.ctrl[`CTRL_GIE] && !st.ctrl[`CTRL_TINT] |=> !st.irq)
      else $error("interrupt without global enable");

   // Power-down is never requested in the cycle after the pin is an output.
   chk_pwr_down_gate: assert property (
      st.ctrl[`CTRL_OE] |=> !power_down)
      else $error("power-down requested while driving");

   // Each false carrier below the limit adds exactly one.
   chk_fc_count: assert property (
      fc_inc && !rdf && (st.false_carrier_tally != `FC_MAX) |=>
         st.false_carrier_tally == $past(st.false_carrier_tally) + 8'h01)
      else $error("false-carrier count did not step");

   // Each qualified receive error below the limit adds exactly one.
   chk_re_count: assert property (
      re_inc && !rdr && (st.rx_error_tally != `RE_MAX) |=>
         st.rx_error_tally == $past(st.rx_error_tally) + 16'h0001)
      else $error("receive error count did not step");

   // Without carrier and valid data no receive error is counted.
   chk_re_carrier: assert property (
      (!carrier_valid || !rx_dv) && !rdr |=> $stable(st.rx_error_tally))
      else $error("receive error counted without carrier");

   // Only the step across the threshold raises the half-full flag.
   chk_fc_once: assert property (
      !st.stat1[1] && !(fc_inc && (fc_base == `FC_HALF)) |=>
         !st.stat1[1])
      else $error("false-carrier half-full raised off threshold");

   // Only the step across the threshold raises the receive flag.
   chk_re_once: assert property (
      !st.stat1[0] && !(re_inc && (re_base == `RE_HALF)) |=>
         !st.stat1[0])
      else $error("receive half-full raised off threshold");

   // A waiting request is answered after exactly one wait state.
   chk_one_wait: assert property (
      s_bus_wait ##1 (read || write) |-> !waitrequest)
      else $error("access not answered after one wait state");

endmodule // phy_event_irq

// file: verification/mgmt_host.sv
// Management host model: an Avalon-MM master with waitrequest.
// Assumes one clock, mclk, shared with the slave it talks to.
module mgmt_host (
   input  wire logic        mclk,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   output logic [7:0]       address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   output logic [3:0]       byteenable
);
   timeunit 1ns;
   timeprecision 1ns;
   int timeouts; // Transfers that never saw waitrequest low.

   // Idle bus at time zero.
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'hf;
      timeouts = 0;
   end

   // One transfer; the request is held until waitrequest is sampled low
   // at a rising edge, and read data are taken at that same edge.
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {16'h0000, d};
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      // The accepting edge: read data stand here, then release.
      q = readdata[15:0];
      if (waitrequest !== 1'b0) timeouts++;
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule // mgmt_host

// file: verification/tb_top.sv
// Self-checking bench for the event status and counter block.
// Assumes the design files are compiled first.
`define CHK(g, e) check(g, e)
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, resetn, read, write, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata;
   logic [3:0]  byteenable;
   logic [10:0] ev;       // Link change to jabber events.
   logic        fce, rse, rx_dv, carrier_valid, mii_loopback;
   logic        pd_level; // Level the board puts on the shared pin.
   logic        int_pin_in, int_pin_out, int_pin_oe, power_down;
   logic [15:0] q, q2;
   int          err_count, num_checks, ecount, e0;
   typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d;} row_s;
   // Writes carry data; reads carry the expected value.
   localparam row_s rows [15] = '{
      '{1'b0, 8'h44, 16'h0008}, '{1'b0, 8'h48, 16'h0000},
      '{1'b0, 8'h4c, 16'h0000}, '{1'b0, 8'h50, 16'h0000},
      '{1'b0, 8'h54, 16'h0000}, '{1'b1, 8'h48, 16'hffff},
      '{1'b0, 8'h48, 16'h003f}, '{1'b1, 8'h4c, 16'hffff},
      '{1'b0, 8'h4c, 16'h007f}, '{1'b1, 8'h50, 16'h00ff},
      '{1'b0, 8'h50, 16'h0000}, '{1'b1, 8'h30, 16'h00ff},
      '{1'b0, 8'h30, 16'h0000}, '{1'b1, 8'h48, 16'h0000},
      '{1'b1, 8'h4c, 16'h0000}};

   // The pin level is the design's drive while enabled, else the board's.
   assign int_pin_in = int_pin_oe ? int_pin_out : pd_level;

   mgmt_host mgmt_host_inst (.mclk(mclk), .waitrequest(waitrequest),
      .readdata(readdata), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable));

   phy_event_irq phy_event_irq_inst (.mclk(mclk), .resetn(resetn),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .ev_link_change(ev[10]),
      .ev_speed_change(ev[9]), .ev_duplex_change(ev[8]),
      .ev_negotiation_complete(ev[7]), .ev_negotiation_error(ev[6]),
      .ev_page_received(ev[5]), .ev_loopback_fifo_fault(ev[4]),
      .ev_crossover_change(ev[3]), .ev_sleep(ev[2]),
      .ev_polarity_change(ev[1]), .ev_jabber(ev[0]),
      .false_carrier_event(fce), .rx_symbol_error(rse), .rx_dv(rx_dv),
      .carrier_valid(carrier_valid), .mii_loopback(mii_loopback),
      .int_pin_in(int_pin_in), .int_pin_out(int_pin_out),
      .int_pin_oe(int_pin_oe), .power_down(power_down));

   // Clock of 100 ns period.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Counts receive errors that qualify, as the design samples them.
   always @(posedge mclk) begin
      if (rse && rx_dv && carrier_valid && !mii_loopback) ecount++;
   end

   // Compares and counts; a mismatch is printed at once.
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Register write and read through the host model.
   // A transfer that never gets its answer ends the run at once.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      mgmt_host_inst.xfer(1'b1, a, d, q2);
      if (mgmt_host_inst.timeouts != 0) give_verdict();
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      mgmt_host_inst.xfer(1'b0, a, 16'h0000, q);
      if (mgmt_host_inst.timeouts != 0) give_verdict();
      `CHK(q, e);
   endtask

   // One-cycle event pulses, and bursts of counter events.
   task automatic evp(input logic [10:0] m);
      @(posedge mclk) ev <= m;
      @(posedge mclk) ev <= 11'h000;
   endtask
   task automatic fc(input int n);
      @(posedge mclk) fce <= 1'b1;
      repeat (n - 1) @(posedge mclk);
      @(posedge mclk) fce <= 1'b0;
   endtask
   task automatic rx(input int n);
      @(posedge mclk) rse <= 1'b1;
      repeat (n - 1) @(posedge mclk);
      @(posedge mclk) rse <= 1'b0;
   endtask
   // The interrupt path settles two edges after its cause.
   task automatic settle;
      repeat (4) @(negedge mclk);
   endtask

   // Closing report and verdict.
   task automatic give_verdict;
      err_count += mgmt_host_inst.timeouts;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence: reset, table of register cases, then hand cases.
   initial begin
      {resetn, ev, fce, rse, rx_dv, carrier_valid, mii_loopback} = '0;
      {err_count, num_checks, ecount} = '0;
      pd_level = 1'b1;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      `CHK(16'(int_pin_out), 16'h0001);
      `CHK(16'(int_pin_oe), 16'h0000);
      for (int i = 0; i < 15; i++) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d);
      end
      // Events latch with every enable off, then clear on read.
      evp(11'h7ff);
      rd(8'h48, 16'h3c00);
      rd(8'h48, 16'h0000);
      rd(8'h4c, 16'h7f00);
      rd(8'h4c, 16'h0000);
      // Both control enables are set by the host before events count.
      wr(8'h48, 16'h0020);
      wr(8'h44, 16'h000b);
      evp(11'h400);
      settle();
      `CHK(16'(int_pin_out), 16'h0000);
      `CHK(16'(int_pin_oe), 16'h0001);
      rd(8'h48, 16'h2020);
      settle();
      `CHK(16'(int_pin_out), 16'h0001);
      wr(8'h44, 16'h0009);
      evp(11'h400);
      settle();
      `CHK(16'(int_pin_out), 16'h0001);
      rd(8'h48, 16'h2020);
      wr(8'h44, 16'h000d);
      settle();
      `CHK(16'(int_pin_out), 16'h0000);
      wr(8'h44, 16'h0005);
      settle();
      `CHK(16'(int_pin_out), 16'h0001);
      wr(8'h44, 16'h0000);
      pd_level <= 1'b0;
      settle();
      `CHK(16'(power_down), 16'h0001);
      @(posedge mclk) pd_level <= 1'b1;
      wr(8'h48, 16'h0000);
      // False-carrier counter: crossing, three more events, saturation.
      fc(128);
      rd(8'h48, 16'h0200);
      fc(3);
      rd(8'h48, 16'h0000);
      rd(8'h50, 16'h0083);
      rd(8'h50, 16'h0000);
      fc(300);
      rd(8'h50, 16'h00ff);
      rd(8'h48, 16'h0200);
      // Receive errors count only with carrier and valid data.
      {carrier_valid, rx_dv} <= 2'b11;
      rx(5);
      rd(8'h54, 16'h0005);
      rx_dv <= 1'b0;
      rx(5);
      rd(8'h54, 16'h0000);
      {rx_dv, mii_loopback} <= 2'b11;
      rx(5);
      rd(8'h54, 16'h0000);
      mii_loopback <= 1'b0;
      // Errors keep arriving during clearing reads; none may be lost.
      e0 = ecount;
      // One error per cycle: each read returns the count at its capture.
      @(posedge mclk) rse <= 1'b1;
      rd(8'h54, 16'h0001);
      q2 = q;
      rd(8'h54, 16'h0003);
      q2 = q2 + q;
      @(posedge mclk) rse <= 1'b0;
      rd(8'h54, 16'h0003);
      `CHK(16'(q2 + q), 16'(ecount - e0));
      rx(32'h0001_0002);
      rd(8'h54, 16'hffff);
      rd(8'h48, 16'h0100);
      // Reset in mid-run returns enables, control and the false-carrier count to rest.
      wr(8'h48, 16'h003f);
      fc(1);
      @(posedge mclk) resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      `CHK(16'(int_pin_out), 16'h0001);
      `CHK(16'(int_pin_oe), 16'h0000);
      rd(8'h44, 16'h0008);
      rd(8'h48, 16'h0000);
      rd(8'h50, 16'h0000);
      give_verdict();
   end
endmodule // tb_top
